// file: rtl/tcwd_pkg.sv
// Package with the register map, field layout and reset values of the timer.
package tcwd_pkg;

  // Byte offsets of the registers on the bus.
  localparam logic [7:0] TCWD_OFF_COUNT  = 8'h00; // Time clock counter.
  localparam logic [7:0] TCWD_OFF_TCCTRL = 8'h04; // Counter control.
  localparam logic [7:0] TCWD_OFF_WDCTRL = 8'h08; // Watchdog control.
  localparam logic [7:0] TCWD_OFF_CMD    = 8'h0C; // Instruction strobes.
  localparam logic [7:0] TCWD_OFF_STATUS = 8'h10; // Live counter state.

  // Field positions in the counter control register.
  localparam int TCWD_TC_INT_EDGE_BIT = 7; // Interrupt edge select.
  localparam int TCWD_TC_GIE_BIT      = 6; // Global interrupt flag, read only.
  localparam int TCWD_TC_SRC_BIT      = 5; // Count source select.
  localparam int TCWD_TC_EDGE_BIT     = 4; // Count edge select.
  localparam int TCWD_TC_PRESCALER_ASSIGN_BIT_BIT     = 3; // Prescaler assign bit.
  localparam int TCWD_TC_RATE_LSB     = 0; // Rate select, three bits.

  // Field positions in the watchdog control register.
  localparam int TCWD_WD_EN_BIT   = 3; // Watchdog enable bit.
  localparam int TCWD_WD_RATE_LSB = 0; // Rate select, three bits.

  // Bit positions in the instruction strobe register.
  localparam int TCWD_CMD_CLR_BIT   = 0; // Watchdog clear instruction.
  localparam int TCWD_CMD_SLEEP_BIT = 1; // Sleep entry instruction.

  // Field positions in the status register.
  localparam int TCWD_ST_WDCNT_LSB = 0;  // Watchdog counter.
  localparam int TCWD_ST_WDPRE_LSB = 8;  // Watchdog prescaler.
  localparam int TCWD_ST_TCPRE_LSB = 16; // Counter prescaler.

  // Reset values.
  localparam logic [7:0] TCWD_COUNT_RST  = 8'h00;
  localparam logic [7:0] TCWD_PRE_RST    = 8'h00;
  localparam logic [6:0] TCWD_TCCTRL_RST = 7'h7F;
  localparam logic [3:0] TCWD_WDCTRL_RST = 4'h7;

  // Counter control fields, without the read-only flag.
  typedef struct packed {
    logic       int_edge; // Interrupt edge select, stored only.
    logic       src;      // 0: instruction cycle, 1: external pin.
    logic       edge_sel; // 0: rising edge, 1: falling edge.
    logic       prescaler_assign_bit;     // 0: rate 1:1, 1: rate select applies.
    logic [2:0] rate;     // Counter rate select.
  } tcwd_tc_ctrl_t;

  // Watchdog control fields.
  typedef struct packed {
    logic       en;   // Watchdog enable bit.
    logic [2:0] rate; // Watchdog rate select.
  } tcwd_wd_ctrl_t;

endpackage : tcwd_pkg

// file: rtl/tcwd_top.sv
// Time clock counter and watchdog with their prescalers, on AHB-Lite.
//
// Function
// R1: Two separate 8-bit prescalers, counter and watchdog.
// R2: Counter rate select picks counter division.
// R3: Watchdog rate select picks watchdog division.
// R4: Writing the counter clears its prescaler.
// R5: Watchdog clear or sleep clears watchdog prescaler.
// R6: Counter is 8-bit, readable, writable, counts up.
// R7: Count source and pin edge are selectable.
// R8: Internal source, no prescale: one per cycle.
// R9: External source: one per selected pin edge.
// R10: Watchdog runs from sub-oscillator, always.
// R11: Enabled watchdog timeout when awake resets device.
// R12: Software may toggle watchdog enable anytime awake.
// R13: Timeout is ratio times 256 half-rate periods.
// R14: Reset from power-on, watchdog, or reset pin.
// R15: Reset clears both counters and both prescalers.
// R16: Reset sets counter control bits, flag excepted.
// R17: Source bit: 0 instruction clock, 1 pin.
// R18: Edge bit: 0 rising, 1 falling.
// R19: Assign bit 0 gives 1:1, else 1:2..1:256.
// R20: Watchdog rate gives 1:1 up to 1:128.
// R21: Counter wraps to zero and flags overflow.
// R22: Counter pin is synchronised before edge detect.
`timescale 1ns/1ps
`default_nettype none

module tcwd_top
  import tcwd_pkg::*;
#(
  parameter int CNT_W = 8 // Counter and prescaler width.
) (
  // Clock, reset and clock enable.
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        ce_i,
  // AHB-Lite slave port.
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Core side.
  input  wire logic        instr_cycle_i,
  input  wire logic        gie_i,
  input  wire logic        cpu_sleep_i,
  // Pins.
  input  wire logic        count_pin_i,
  input  wire logic        sub_osc_i,
  input  wire logic        reset_pin_n_i,
  // Events and reset request.
  output logic             tc_overflow_o,
  output logic             wd_wake_o,
  output logic             dev_reset_o
);

  // Prescaler carry for counter and watchdog: low bits selected by width are all ones.
  function automatic logic tcwd_carry(input logic [CNT_W-1:0] pre,
                                      input logic [3:0]       nbits);
    logic [CNT_W-1:0] mask;
    mask = '0;
    for (int i = 0; i < CNT_W; i++)
    begin
      mask[i] = (i < int'(nbits));
    end
    tcwd_carry = ((pre & mask) == mask);
  endfunction : tcwd_carry

  // Register state.
  logic [CNT_W-1:0] count_reg;     // Time clock counter.
  logic [CNT_W-1:0] tc_pre_reg;    // Counter prescaler.
  logic [CNT_W-1:0] wd_cnt_reg;    // Watchdog counter.
  logic [CNT_W-1:0] wd_pre_reg;    // Watchdog prescaler.
  tcwd_tc_ctrl_t    tc_ctrl_reg;   // Counter control fields.
  tcwd_wd_ctrl_t    wd_ctrl_reg;   // Watchdog control fields.
  logic             wd_reset_reg;  // Watchdog timeout reset pulse.
  logic             wd_wake_reg;   // Watchdog timeout while asleep.
  logic             tc_ovf_reg;    // Counter overflow pulse.

  // Synchronisers for the three asynchronous pins.
  logic [1:0] pin_sync_reg;        // Counter pin, two stages.
  logic       pin_last_reg;        // Previous synchronised level.
  logic [1:0] sub_sync_reg;        // Sub-oscillator, two stages.
  logic       sub_last_reg;        // Previous synchronised level.
  logic       half_reg;            // Divides the sub-oscillator by two.
  logic [1:0] rst_sync_reg;        // Reset pin, two stages.

  // Bus state.
  logic             wr_pend_reg;   // Write data phase in progress.
  logic             rd_wait_reg;   // Read data phase, first cycle.
  logic [7:0]       addr_reg;      // Captured byte offset.
  logic [31:0]      rdata_reg;     // Read data, held until next read.

  // Derived strobes.
  logic             soft_rst;      // Synchronous reset of the block.
  logic             addr_take;     // Address phase accepted.
  logic             wr_count;      // Counter written this cycle.
  logic             wr_cmd;        // Instruction strobe written.
  logic             wd_clear;      // Watchdog clear instruction.
  logic             wd_sleep;      // Sleep entry instruction.
  logic             pin_edge;      // Selected edge seen on the pin.
  logic             src_tick;      // Counter source event.
  logic             tc_tick;       // Counter advance after prescale.
  logic             fs_rise;       // Rising sub-oscillator edge.
  logic             half_tick;     // One period of half the rate.
  logic             wd_tick;       // Watchdog advance after prescale.
  logic             wd_timeout;    // Watchdog passes its maximum.
  logic [31:0]      rd_mux;        // Read value of the addressed word.

  // The reset pin is asynchronous, so only its second stage is used.
  assign soft_rst = wd_reset_reg | ~rst_sync_reg[1]; // R14

  // Writes are taken in the data phase that follows the address phase.
  assign addr_take = hsel_i & hready_i & htrans_i[1];
  assign wr_count  = wr_pend_reg & (addr_reg == TCWD_OFF_COUNT);
  assign wr_cmd    = wr_pend_reg & (addr_reg == TCWD_OFF_CMD);
  assign wd_clear  = wr_cmd & hwdata_i[TCWD_CMD_CLR_BIT];
  assign wd_sleep  = wr_cmd & hwdata_i[TCWD_CMD_SLEEP_BIT];

  // Rising edge when the edge bit is 0, falling edge when it is 1.
  assign pin_edge = tc_ctrl_reg.edge_sel ?
                    (pin_last_reg & ~pin_sync_reg[1]) :
                    (~pin_last_reg & pin_sync_reg[1]); // R9 R18 R22

  // Source select: instruction cycle or pin edge.
  assign src_tick = tc_ctrl_reg.src ? pin_edge : instr_cycle_i; // R7 R17

  // Without the prescaler every source event advances the counter.
  assign tc_tick = src_tick & (~tc_ctrl_reg.prescaler_assign_bit |
                   tcwd_carry(tc_pre_reg,
                              {1'b0, tc_ctrl_reg.rate} + 4'h1)); // R8 R19 R2

  // The watchdog prescaler ticks on every second sub-oscillator rising edge.
  assign fs_rise   = sub_sync_reg[1] & ~sub_last_reg;
  assign half_tick = fs_rise & half_reg; // R13
  assign wd_tick   = half_tick &
                     tcwd_carry(wd_pre_reg, {1'b0, wd_ctrl_reg.rate}); // R3 R20
  assign wd_timeout = wd_tick & (&wd_cnt_reg); // R13

  // Pin synchronisers; the first stage feeds only the second.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pin_sync_reg <= 2'h0;
      pin_last_reg <= 1'b0;
      sub_sync_reg <= 2'h0;
      sub_last_reg <= 1'b0;
      rst_sync_reg <= 2'h0;
    end
    else if (ce_i)
    begin
      pin_sync_reg <= {pin_sync_reg[0], count_pin_i}; // R22
      pin_last_reg <= pin_sync_reg[1];
      sub_sync_reg <= {sub_sync_reg[0], sub_osc_i};
      sub_last_reg <= sub_sync_reg[1];
      rst_sync_reg <= {rst_sync_reg[0], reset_pin_n_i};
    end
  end

  // Bus address phase capture and read wait state.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wr_pend_reg <= 1'b0;
      rd_wait_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end
    else if (ce_i)
    begin
      // A new address phase can only be taken while hready is high.
      wr_pend_reg <= addr_take & hwrite_i;
      rd_wait_reg <= addr_take & ~hwrite_i;
      if (addr_take)
      begin
        addr_reg <= haddr_i[7:0];
      end
    end
  end

  // Read multiplexer; unmapped offsets read as zero.
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (addr_reg)
      TCWD_OFF_COUNT:
      begin
        rd_mux[CNT_W-1:0] = count_reg; // R6
      end
      TCWD_OFF_TCCTRL:
      begin
        rd_mux[TCWD_TC_INT_EDGE_BIT] = tc_ctrl_reg.int_edge;
        rd_mux[TCWD_TC_GIE_BIT]      = gie_i;
        rd_mux[TCWD_TC_SRC_BIT]      = tc_ctrl_reg.src;
        rd_mux[TCWD_TC_EDGE_BIT]     = tc_ctrl_reg.edge_sel;
        rd_mux[TCWD_TC_PRESCALER_ASSIGN_BIT_BIT]     = tc_ctrl_reg.prescaler_assign_bit;
        rd_mux[TCWD_TC_RATE_LSB+:3]  = tc_ctrl_reg.rate;
      end
      TCWD_OFF_WDCTRL:
      begin
        rd_mux[TCWD_WD_EN_BIT]      = wd_ctrl_reg.en;
        rd_mux[TCWD_WD_RATE_LSB+:3] = wd_ctrl_reg.rate;
      end
      TCWD_OFF_STATUS:
      begin
        rd_mux[TCWD_ST_WDCNT_LSB+:CNT_W] = wd_cnt_reg;
        rd_mux[TCWD_ST_WDPRE_LSB+:CNT_W] = wd_pre_reg;
        rd_mux[TCWD_ST_TCPRE_LSB+:CNT_W] = tc_pre_reg;
      end
      default:
      begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Read data is sampled in the wait cycle and then held.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rdata_reg <= 32'h0000_0000;
    end
    else if (ce_i && rd_wait_reg)
    begin
      rdata_reg <= rd_mux;
    end
  end

  // Control registers; a watchdog or pin reset restores them too.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tc_ctrl_reg <= TCWD_TCCTRL_RST; // R16
      wd_ctrl_reg <= TCWD_WDCTRL_RST;
    end
    else if (ce_i)
    begin
      if (soft_rst)
      begin
        tc_ctrl_reg <= TCWD_TCCTRL_RST; // R16
        wd_ctrl_reg <= TCWD_WDCTRL_RST;
      end
      else if (wr_pend_reg && addr_reg == TCWD_OFF_TCCTRL)
      begin
        // The flag bit is not stored; it always mirrors the core.
        tc_ctrl_reg.int_edge <= hwdata_i[TCWD_TC_INT_EDGE_BIT];
        tc_ctrl_reg.src      <= hwdata_i[TCWD_TC_SRC_BIT];
        tc_ctrl_reg.edge_sel <= hwdata_i[TCWD_TC_EDGE_BIT];
        tc_ctrl_reg.prescaler_assign_bit     <= hwdata_i[TCWD_TC_PRESCALER_ASSIGN_BIT_BIT];
        tc_ctrl_reg.rate     <= hwdata_i[TCWD_TC_RATE_LSB+:3]; // R2
      end
      else if (wr_pend_reg && addr_reg == TCWD_OFF_WDCTRL && !cpu_sleep_i)
      begin
        // Enable may change at any time while the core is awake.
        wd_ctrl_reg.en   <= hwdata_i[TCWD_WD_EN_BIT]; // R12
        wd_ctrl_reg.rate <= hwdata_i[TCWD_WD_RATE_LSB+:3]; // R3
      end
    end
  end

  // Time clock counter and its prescaler.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      count_reg  <= TCWD_COUNT_RST; // R15
      tc_pre_reg <= TCWD_PRE_RST;
      tc_ovf_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      tc_ovf_reg <= 1'b0;
      if (soft_rst)
      begin
        count_reg  <= TCWD_COUNT_RST; // R15
        tc_pre_reg <= TCWD_PRE_RST;
      end
      else if (wr_count)
      begin
        // A software write wins over a tick in the same cycle.
        count_reg  <= hwdata_i[CNT_W-1:0]; // R6
        tc_pre_reg <= TCWD_PRE_RST; // R4
      end
      else
      begin
        if (src_tick && tc_ctrl_reg.prescaler_assign_bit)
        begin
          tc_pre_reg <= tc_pre_reg + 1'b1; // R1
        end
        if (tc_tick)
        begin
          // Natural wrap of the width brings the counter back to zero.
          count_reg  <= count_reg + 1'b1; // R6 R21
          tc_ovf_reg <= &count_reg; // R21
        end
      end
    end
  end

  // Half-rate divider for the watchdog time base.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      half_reg <= 1'b0;
    end
    else if (ce_i && fs_rise)
    begin
      half_reg <= ~half_reg; // R13
    end
  end

  // Watchdog counter and prescaler run even while the core sleeps.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wd_cnt_reg <= TCWD_COUNT_RST; // R15
      wd_pre_reg <= TCWD_PRE_RST;
    end
    else if (ce_i)
    begin
      if (soft_rst || wd_clear || wd_sleep)
      begin
        wd_cnt_reg <= TCWD_COUNT_RST; // R5 R15
        wd_pre_reg <= TCWD_PRE_RST; // R5
      end
      else if (half_tick)
      begin
        wd_pre_reg <= wd_pre_reg + 1'b1; // R1 R10
        if (wd_tick)
        begin
          wd_cnt_reg <= wd_cnt_reg + 1'b1; // R10
        end
      end
    end
  end

  // Timeout action: full reset when awake, wake request when asleep.
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wd_reset_reg <= 1'b0;
      wd_wake_reg  <= 1'b0;
    end
    else if (ce_i)
    begin
      wd_reset_reg <= wd_timeout & wd_ctrl_reg.en & ~cpu_sleep_i &
                      ~soft_rst; // R11
      wd_wake_reg  <= wd_timeout & wd_ctrl_reg.en & cpu_sleep_i &
                      ~soft_rst;
    end
  end

  // Outputs; reads insert one wait cycle so data comes from a flop.
  assign hreadyout_o   = ~rd_wait_reg;
  assign hresp_o       = 1'b0;
  assign hrdata_o      = rdata_reg;
  assign tc_overflow_o = tc_ovf_reg;
  assign wd_wake_o     = wd_wake_reg;
  assign dev_reset_o   = soft_rst | ~nrst_i; // R14

endmodule : tcwd_top

`default_nettype wire

// file: testbench/tcwd_properties.sv
// Concurrent checks on the bus and event ports of the timer block.
`timescale 1ns/1ps
`default_nettype none

module tcwd_properties #(
  parameter int CNT_W = 8 // Counter width, handed on from the design.
) (
  // Clock, reset and enable.
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic        ce_i,
  // Bus side.
  input wire logic        hsel_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  // Core, pins and events.
  input wire logic        cpu_sleep_i,
  input wire logic        reset_pin_n_i,
  input wire logic        tc_overflow_o,
  input wire logic        wd_wake_o,
  input wire logic        dev_reset_o
);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  // A transfer is accepted only when selected, ready and non-idle.
  logic taken;
  assign taken = hsel_i && hready_i && htrans_i[1] && ce_i;

  a_resp_always_okay: assert property (hresp_o == 1'b0)
    else $error("Bus response was not OKAY.");
  a_read_one_wait: assert property (taken && !hwrite_i |=>
    !hreadyout_o ##1 hreadyout_o)
    else $error("Read did not take exactly one wait state.");
  a_write_no_wait: assert property (taken && hwrite_i |=> hreadyout_o)
    else $error("Write data phase was stretched.");
  // Read data may only move when a read wait state has just ended.
  a_rdata_holds: assert property (hreadyout_o && $past(hreadyout_o) |->
    $stable(hrdata_o))
    else $error("Read data changed outside a read.");
  a_ovf_one_cycle: assert property (tc_overflow_o |=> !tc_overflow_o)
    else $error("Overflow event lasted more than one cycle.");
  a_wake_needs_sleep: assert property (wd_wake_o |-> $past(cpu_sleep_i))
    else $error("Wake event while the core was awake.");
  a_pin_forces_reset: assert property (!reset_pin_n_i [*2] |=> dev_reset_o)
    else $error("Reset pin low did not reset the device.");
  // The synchroniser keeps the device in reset two edges after release.
  a_release_holds: assert property ($rose(nrst_i) |->
    dev_reset_o ##1 dev_reset_o)
    else $error("Device reset dropped too early after power-on.");

  c_overflow: cover property (tc_overflow_o);
  c_dev_reset: cover property ($rose(dev_reset_o));
  c_read: cover property (taken && !hwrite_i);
  c_wake: cover property (wd_wake_o);

endmodule : tcwd_properties

bind tcwd_top tcwd_properties #(.CNT_W(CNT_W)) u_props (
  .clk_i, .nrst_i, .ce_i, .hsel_i, .htrans_i, .hwrite_i, .hready_i,
  .hrdata_o, .hreadyout_o, .hresp_o, .cpu_sleep_i, .reset_pin_n_i,
  .tc_overflow_o, .wd_wake_o, .dev_reset_o);

`default_nettype wire

// file: testbench/tcwd_top_test.sv
// Self-checking bench for the time clock counter and watchdog block.
`timescale 1ns/1ps
`default_nettype none

module tcwd_top_test
  import tcwd_pkg::*;
;

  // Bench-driven inputs; the free-running ones start at zero here.
  logic        nrst, hsel, hwrite, instr, pin, rst_pin_n, gie, sleep_in;
  logic        clk     = 1'b0; // Driven only by the clock process.
  logic        sub_osc = 1'b0; // Driven only by the oscillator process.
  logic [31:0] haddr, hwdata;
  logic [1:0]  htrans;
  logic [1:0]  sdiv    = 2'h0; // Oscillator divider.
  // Design outputs and captured read data.
  logic [31:0] hrdata, rd;
  logic        hreadyout, hresp, ovf, wake, devrst;
  // Counters of the run.
  int          n_mismatch, n_checks, n_ovf, n_devrst;

  tcwd_top #(.CNT_W(8)) DUT (
    .clk_i(clk), .nrst_i(nrst), .ce_i(1'b1), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
    .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .instr_cycle_i(instr), .gie_i(gie), .cpu_sleep_i(sleep_in),
    .count_pin_i(pin), .sub_osc_i(sub_osc), .reset_pin_n_i(rst_pin_n),
    .tc_overflow_o(ovf), .wd_wake_o(wake), .dev_reset_o(devrst));

  always #20 clk = ~clk;

  // Free-running sub-oscillator, eight clocks a period, never stopped.
  always @(posedge clk)
  begin
    sdiv <= sdiv + 2'h1;
    if (sdiv == 2'h3)
      sub_osc <= ~sub_osc;
  end

  // Event monitors sample at the falling edge, clear of update races.
  always @(negedge clk)
  begin
    if (ovf === 1'b1)
      n_ovf++;
    if (devrst === 1'b1 && nrst === 1'b1)
      n_devrst++;
  end

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask : chk

  // Wait for hready high at a falling edge; capture read data there.
  task automatic wait_rdy;
    int k;
    k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      $display("BAD bus ready expected 1 seen stuck");
      n_mismatch++;
      tally_and_finish();
    end
    rd = hrdata;
    @(posedge clk);
  endtask : wait_rdy

  // One single word transfer: address phase, then data phase.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask : bus

  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [31:0] mask, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd & mask);
  endtask : rd_chk

  task automatic pulses(input int n);
    repeat (n)
    begin
      instr <= 1'b1;
      @(posedge clk);
    end
    instr <= 1'b0;
    @(posedge clk);
  endtask : pulses

  // Pin changes are held long enough to pass the synchroniser.
  task automatic pin_to(input logic v);
    pin <= v;
    repeat (8) @(posedge clk);
  endtask : pin_to

  task automatic t_reset_values;
    rd_chk("counter ctrl", TCWD_OFF_TCCTRL, 32'hFF, 32'hBF);
    // The flag bit is not stored: it shows the core's level live.
    gie <= 1'b1;
    rd_chk("flag mirrors core", TCWD_OFF_TCCTRL, 32'hFF, 32'hFF);
    gie <= 1'b0;
    rd_chk("watchdog ctrl", TCWD_OFF_WDCTRL, 32'hFF, 32'h07);
    rd_chk("counter", TCWD_OFF_COUNT, 32'hFF, 32'h00);
    rd_chk("command read", TCWD_OFF_CMD, 32'hFFFFFFFF, 32'h0);
    rd_chk("unmapped", 8'h14, 32'hFFFFFFFF, 32'h0);
  endtask : t_reset_values

  task automatic t_internal_wrap;
    int o;
    bus(1'b1, TCWD_OFF_TCCTRL, 32'h07);
    bus(1'b1, TCWD_OFF_COUNT, 32'hFE);
    o = n_ovf;
    pulses(3);
    rd_chk("wrapped count", TCWD_OFF_COUNT, 32'hFF, 32'h01);
    chk("overflow events", o + 1, n_ovf);
  endtask : t_internal_wrap

  // Every rate: 2 << r events must give exactly one count.
  task automatic t_rates;
    for (int r = 0; r < 8; r++)
    begin
      bus(1'b1, TCWD_OFF_TCCTRL, 32'h08 | r);
      bus(1'b1, TCWD_OFF_COUNT, 32'h0);
      pulses(2 << r);
      rd_chk("prescaled count", TCWD_OFF_COUNT, 32'hFF, 32'h01);
    end
    pulses(1);
    rd_chk("counter prescaler", TCWD_OFF_STATUS, 32'hFF0000, 32'h10000);
    bus(1'b1, TCWD_OFF_COUNT, 32'h10);
    rd_chk("prescaler cleared", TCWD_OFF_STATUS, 32'hFF0000, 32'h0);
  endtask : t_rates

  task automatic t_pin_edges;
    bus(1'b1, TCWD_OFF_TCCTRL, 32'h20);
    bus(1'b1, TCWD_OFF_COUNT, 32'h0);
    pin_to(1'b1);
    pin_to(1'b0);
    pin_to(1'b1);
    rd_chk("rising edges", TCWD_OFF_COUNT, 32'hFF, 32'h02);
    bus(1'b1, TCWD_OFF_TCCTRL, 32'h30);
    bus(1'b1, TCWD_OFF_COUNT, 32'h0);
    pin_to(1'b0);
    pin_to(1'b1);
    pin_to(1'b0);
    rd_chk("falling edges", TCWD_OFF_COUNT, 32'hFF, 32'h02);
  endtask : t_pin_edges

  // Disabled watchdog never resets; clear and sleep zero its state.
  task automatic t_wd_clear;
    int d;
    bus(1'b1, TCWD_OFF_WDCTRL, 32'h00);
    d = n_devrst;
    repeat (4400) @(posedge clk);
    chk("disabled watchdog resets", d, n_devrst);
    for (int c = 1; c < 3; c++)
    begin
      bus(1'b1, TCWD_OFF_WDCTRL, 32'h00);
      repeat (100) @(posedge clk);
      bus(1'b1, TCWD_OFF_WDCTRL, 32'h07);
      bus(1'b1, TCWD_OFF_CMD, c);
      rd_chk("watchdog cleared", TCWD_OFF_STATUS, 32'hFEFF, 32'h0);
    end
  endtask : t_wd_clear

  // Rate 1:1 times out after 256 half-ticks of sixteen clocks.
  task automatic t_wd_timeout;
    int k;
    bus(1'b1, TCWD_OFF_COUNT, 32'h55);
    bus(1'b1, TCWD_OFF_WDCTRL, 32'h08);
    bus(1'b1, TCWD_OFF_CMD, 32'h1);
    k = 0;
    while (devrst !== 1'b1 && k < 5000)
    begin
      @(negedge clk);
      k++;
    end
    chk("timeout period", 32'h1, {31'h0, k >= 4060 && k <= 4130});
    if (k >= 5000)
      tally_and_finish();
    repeat (4) @(posedge clk);
    rd_chk("ctrl after timeout", TCWD_OFF_TCCTRL, 32'hFF, 32'hBF);
    rd_chk("wd ctrl after timeout", TCWD_OFF_WDCTRL, 32'hFF, 32'h07);
    rd_chk("count after timeout", TCWD_OFF_COUNT, 32'hFF, 32'h0);
  endtask : t_wd_timeout

  // Asleep, a timeout only wakes the core and watchdog control writes are ignored.
  task automatic t_wd_sleep;
    int k;
    int d;
    bus(1'b1, TCWD_OFF_WDCTRL, 32'h08);
    bus(1'b1, TCWD_OFF_CMD, 32'h1);
    d = n_devrst;
    sleep_in <= 1'b1;
    bus(1'b1, TCWD_OFF_WDCTRL, 32'h00);
    rd_chk("wd ctrl in sleep", TCWD_OFF_WDCTRL, 32'hFF, 32'h08);
    k = 0;
    while (wake !== 1'b1 && k < 5000)
    begin
      @(negedge clk);
      k++;
    end
    chk("wake in sleep", 32'h1, {31'h0, k < 5000});
    chk("resets in sleep", d, n_devrst);
    if (k >= 5000)
      tally_and_finish();
    @(posedge clk);
    sleep_in <= 1'b0;
    bus(1'b1, TCWD_OFF_WDCTRL, 32'h00);
  endtask : t_wd_sleep

  task automatic t_pin_reset;
    bus(1'b1, TCWD_OFF_TCCTRL, 32'h00);
    bus(1'b1, TCWD_OFF_COUNT, 32'h33);
    rst_pin_n <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("pin reset", 32'h1, {31'h0, devrst});
    @(posedge clk);
    rst_pin_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk("ctrl after pin", TCWD_OFF_TCCTRL, 32'hFF, 32'hBF);
    rd_chk("count after pin", TCWD_OFF_COUNT, 32'hFF, 32'h0);
  endtask : t_pin_reset

  initial
  begin
    nrst = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    instr = 1'b0;
    pin = 1'b0;
    rst_pin_n = 1'b1;
    gie = 1'b0;
    sleep_in = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset_values();
    t_internal_wrap();
    t_rates();
    t_pin_edges();
    t_wd_clear();
    t_wd_timeout();
    t_wd_sleep();
    t_pin_reset();
    tally_and_finish();
  end

endmodule : tcwd_top_test

`default_nettype wire
